// >>> hw/operation_status_and_selftest.v
// operation condition register, self-test query and trace prefix handling
`timescale 1ns/1ps
`default_nettype none
`include "op_status_map.vh"
module operation_status_and_selftest #(
  parameter ERRW = 8
) (
  input wire clk_sys, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire calBusy, // calibrate_command operation running
  input wire sweepStart, // begin-acquisition command executes, pulse
  input wire sweepDone, // acquisition completed, pulse
  input wire abortReq, // abort command received, pulse
  input wire abortDone, // abort processing finished, pulse
  input wire condQuery, // condition query, pulse
  input wire testQuery, // full self-test query, pulse
  input wire testDone, // self-test engine finished, pulse
  input wire testFail, // self-test result, valid with testDone
  input wire [ERRW-1:0] testErrCode, // failure detail, valid with testDone
  input wire traceCmd, // waveform command, trace prefix
  input wire dataCmd, // waveform command, data prefix
  output reg [15:0] condData, // query answer
  output reg condValid, // answer strobe, pulse
  output reg testStart, // start pulse to self-test engine
  output reg resultValid, // self-test answer strobe, pulse
  output reg resultPass, // 1 pass, 0 fail
  output reg errPush, // error queue write strobe
  output reg [ERRW-1:0] errCode, // error queue entry
  output reg waveCmd // unified waveform command pulse
);

  // ----------------------------------------
  // local constants
  // ----------------------------------------
  localparam CW = `COND_WIDTH;
  localparam [CW-1:0] USED_MASK = `COND_USED_MASK;
  localparam [CW-1:0] RESET_WORD = `COND_RESET;
  // self-test sequencer states, one-hot
  localparam [1:0] TS_IDLE = 2'h1;
  localparam [1:0] TS_RUN = 2'h2;

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  reg calFlag_r;
  reg [1:0] testState_r;
  reg [1:0] testState_nxt;
  reg [CW-1:0] condWord;
  wire sweepFlag;
  wire abortFlag;
  wire testFlag;
  wire testIdle;
  wire sweepEnd;
  wire testAccept;
  wire testFinish;
  wire testFailed;
  wire waveAny;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  // abort ends a sweep
  assign sweepEnd = sweepDone || abortReq;
  assign testIdle = (testState_r == TS_IDLE);
  assign testFlag = (testState_r == TS_RUN);
  assign testAccept = testQuery && testIdle;
  // a stray done with no test running is dropped
  assign testFinish = testDone && testFlag;
  assign testFailed = testFinish && testFail;
  assign waveAny = traceCmd || dataCmd;

  // ----------------------------------------
  // activity flags
  // ----------------------------------------
  // tracks calibrate_command activity
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      calFlag_r <= 1'h0;
    end else begin
      calFlag_r <= calBusy;
    end
  end

  op_flag_cell sweep_cell_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .setPulse(sweepStart),
    .clrPulse(sweepEnd),
    .flag_r(sweepFlag)
  );

  op_flag_cell abort_cell_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .setPulse(abortReq),
    .clrPulse(abortDone),
    .flag_r(abortFlag)
  );

  // ----------------------------------------
  // self-test sequencer
  // ----------------------------------------
  // run state is testing flag
  always @* begin
    testState_nxt = testState_r;
    case (testState_r)
      TS_IDLE: begin
        if (testQuery) begin
          testState_nxt = TS_RUN;
        end
      end
      TS_RUN: begin
        if (testDone) begin
          testState_nxt = TS_IDLE;
        end
      end
      default: begin
        // a corrupted state falls back to idle
        testState_nxt = TS_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      testState_r <= TS_IDLE;
    end else begin
      testState_r <= testState_nxt;
    end
  end

  // ----------------------------------------
  // condition word
  // ----------------------------------------
  // fixed positions, lsb bit 0
  always @* begin
    condWord = RESET_WORD;
    condWord[`COND_CAL_BIT] = calFlag_r;
    condWord[`COND_SWEEP_BIT] = sweepFlag;
    condWord[`COND_TEST_BIT] = testFlag;
    condWord[`COND_ABORT_BIT] = abortFlag;
    condWord = condWord & USED_MASK;
  end

  // ----------------------------------------
  // condition query answer
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      condData <= RESET_WORD;
      condValid <= 1'h0;
    end else begin
      condValid <= condQuery;
      if (condQuery) begin
        condData <= condWord;
      end
    end
  end

  // ----------------------------------------
  // self-test answer
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      testStart <= 1'h0;
      resultValid <= 1'h0;
      resultPass <= 1'h0;
    end else begin
      testStart <= testAccept;
      resultValid <= testFinish;
      if (testFinish) begin
        resultPass <= !testFail;
      end
    end
  end

  // ----------------------------------------
  // error queue feed
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      errPush <= 1'h0;
      errCode <= {ERRW{1'h0}};
    end else begin
      errPush <= testFailed;
      if (testFailed) begin
        errCode <= testErrCode;
      end
    end
  end

  // ----------------------------------------
  // waveform command merge
  // ----------------------------------------
  // one pulse per cycle with either prefix; trace and data in the same cycle give a single pulse
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      waveCmd <= 1'h0;
    end else begin
      waveCmd <= waveAny;
    end
  end
endmodule

// ----------------------------------------
// set/clear flag cell
// ----------------------------------------
module op_flag_cell (
  input wire clk_sys, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire setPulse, // raise the flag
  input wire clrPulse, // drop the flag
  output reg flag_r // flag state
);
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      flag_r <= 1'h0;
    end else if (setPulse) begin
      // set wins so a same-cycle end cannot lose a start
      flag_r <= 1'h1;
    end else if (clrPulse) begin
      flag_r <= 1'h0;
    end
  end
endmodule
`default_nettype wire

// >>> hw/op_status_map.vh
// register map constants for the operation condition and self-test block
`ifndef OP_STATUS_MAP_VH
`define OP_STATUS_MAP_VH
`define COND_WIDTH 16
`define COND_RESET 16'h0000
`define COND_CAL_BIT 0
`define COND_SWEEP_BIT 3
`define COND_TEST_BIT 8
`define COND_ABORT_BIT 9
`define COND_USED_MASK 16'h0309
`define ERR_CODE_WIDTH 8
`define ERR_NONE 8'h00
`endif

// >>> dv/op_status_chk.sv
// checker for the condition register and self-test ports
`timescale 1ns/1ps
`default_nettype none
module op_status_chk(
  input wire clk_sys, sys_rst, calBusy, sweepStart, abortReq, condQuery,
  input wire testDone, testFail, traceCmd, dataCmd, condValid, testStart,
  input wire resultValid, resultPass, errPush, waveCmd,
  input wire [15:0] condData
);
default clocking @(posedge clk_sys); endclocking
default disable iff (sys_rst);
sequence sweepThenQuery;
  sweepStart ##1 condQuery;
endsequence
sequence abortThenQuery;
  abortReq && !sweepStart ##1 condQuery;
endsequence
AST_CAL: assert property (condQuery|=>condData[0]==$past(calBusy,2)) else $error("cal");
AST_VAL: assert property (condQuery|=>condValid&&!(condData&16'hFCF6)) else $error("val");
AST_SWP: assert property (sweepThenQuery |=> condData[3]) else $error("swp");
AST_ABT: assert property (abortThenQuery |=> condData[9]) else $error("abt");
AST_TST: assert property (testStart&&condQuery|=>condData[8]) else $error("tst");
AST_RES: assert property (resultValid|->resultPass!=$past(testFail)) else $error("res");
AST_ERR: assert property (errPush==(resultValid&&!resultPass)) else $error("err");
AST_WAV: assert property (traceCmd||dataCmd|=>waveCmd) else $error("wav");
endmodule
bind operation_status_and_selftest op_status_chk chk(.*);
`default_nettype wire

// >>> dv/selftest_model.sv
// self-test engine that answers after a set latency
`timescale 1ns/1ps
`default_nettype none
module selftest_model(
  input wire clk_sys, testStart, failMode, // clock, start, result
  input wire [2:0] lat, // answer latency
  output logic testDone = 0, testFail = 0 // result pulse
);
int n = 0;
always @(posedge clk_sys) begin
  testDone <= n == 1;
  testFail <= failMode;
  n <= testStart ? lat : n ? n - 1 : 0;
end
endmodule
`default_nettype wire

// >>> dv/tb_operation_status_and_selftest.sv
// bench for the condition register and self-test query
`timescale 1ns/1ps
`default_nettype none
module tb_operation_status_and_selftest;
logic clk_sys=0, sys_rst=1, calBusy=0, sweepStart=0, sweepDone=0, abortReq=0, abortDone=0;
logic condQuery=0, testQuery=0, traceCmd=0, dataCmd=0, failMode=0, testDone, testFail;
logic condValid, testStart, resultValid, resultPass, errPush, waveCmd;
logic [15:0] condData;
logic [2:0] lat=1;
logic [7:0] errCode, errIn=8'h00;
int fail_count=0, total_checks=0;
always #10 clk_sys = ~clk_sys;
operation_status_and_selftest operation_status_and_selftest_i(.clk_sys, .sys_rst, .calBusy,
  .sweepStart, .sweepDone, .abortReq, .abortDone, .condQuery, .testQuery, .testDone,
  .testFail, .testErrCode(errIn), .traceCmd, .dataCmd, .condData, .condValid, .testStart,
  .resultValid, .resultPass, .errPush, .errCode(errCode), .waveCmd);
selftest_model selftest_model_i(.clk_sys, .testStart, .failMode, .lat, .testDone, .testFail);
task chk(input [15:0] a, e);
  total_checks++;
  if (a !== e) begin
    fail_count++;
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
  end
endtask
task q(input [15:0] e);
  condQuery <= 1;
  @(posedge clk_sys);
  condQuery <= 0;
  #1;
  chk(condValid, 1);
  chk(condData, e);
  @(posedge clk_sys);
endtask
task t_reset;
  q(16'h0000);
  $display("reset test done");
endtask
task t_flags;
  calBusy <= 1;
  sweepStart <= 1;
  @(posedge clk_sys);
  sweepStart <= 0;
  q(16'h0009);
  sweepDone <= 1;
  @(posedge clk_sys);
  sweepDone <= 0;
  q(16'h0001);
  sweepStart <= 1;
  @(posedge clk_sys);
  sweepStart <= 0;
  abortReq <= 1;
  @(posedge clk_sys);
  abortReq <= 0;
  q(16'h0201);
  calBusy <= 0;
  abortDone <= 1;
  @(posedge clk_sys);
  abortDone <= 0;
  q(16'h0000);
  $display("flags test done");
endtask
task t_test(input f, input [2:0] l);
  failMode <= f;
  lat <= l;
  errIn <= {5'h14, l};
  testQuery <= 1;
  @(posedge clk_sys);
  testQuery <= 0;
  q(16'h0100);
  for (int i = 0; i < 20 && resultValid !== 1; i++) @(posedge clk_sys) #1;
  chk(resultValid, 1);
  chk(resultPass, !f);
  chk(errPush, f);
  if (f) chk(errCode, {5'h14, l});
  @(posedge clk_sys);
  q(16'h0000);
  $display("self-test test done");
endtask
task t_wave;
  traceCmd <= 1;
  @(posedge clk_sys);
  traceCmd <= 0;
  #1;
  chk(waveCmd, 1);
  @(posedge clk_sys);
  dataCmd <= 1;
  @(posedge clk_sys);
  dataCmd <= 0;
  #1;
  chk(waveCmd, 1);
  @(posedge clk_sys);
  $display("waveform prefix test done");
endtask
task finish_test;
  $display("checks %0d fails %0d", total_checks, fail_count);
  if (fail_count == 0 && total_checks > 0) $display("Result: passed");
  else $display("Result: failed");
  $finish;
endtask
initial begin
  #100000 fail_count++;
  finish_test;
end
initial begin
  repeat (16) @(posedge clk_sys);
  sys_rst <= 0;
  @(posedge clk_sys);
  t_reset;
  t_flags;
  t_test(0, 3'h1);
  t_test(1, 3'h6);
  t_wave;
  finish_test;
end
endmodule
`default_nettype wire
